/* File: verilog/msr_pkg.sv */
// package: register map, field layout and structs for the stats/memory/config register bank
//------------------------------------------------------------------------------
// Overview of operation
// R1: set abort flag, drop frames over 1532 bytes
// R2: abort flag sticks until reset or zero write
// R3: half duplex rejects own transmitted frames
// R4: four separate 4-bit transmit event counters
// R5: interrupt when any counter reaches 15
// R6: reading counter register clears all counters
// R7: counters saturate at 15, never wrap
// R8: each counter advances once per packet
// R9: one collision single; 2..16 collisions multiple
// R10: deferred counter advances once per deferred packet
// R11: memory units are 256 times multiplier one
// R12: free memory readable; reloads on resets
// R13: total memory size constant 18H
// R14: nonzero reservation denies receive at or below
// R15: reservation cleared by reset, kept by manager reset
// R16: bits 11:9 encode multiplier, 001 means one
// R17: no-wait clear stretches every cycle two-three clocks
// R18: port select AUI set, full-step resets low
// R19: low squelch selects 240mV, resets clear
// R20: wide bus forced high while strap low
// R21: link test off: link good, LED lit
// R22: link failed: clear link good, suppress cable data
// R23: ISA irq routed to selected pin, others tristated
// R24: counter layout single, multiple, deferred, excessive
// R25: excessive-deferral counter same as others
//------------------------------------------------------------------------------
package msr_pkg;
	// register offsets
	localparam logic [3:0] OFF_CONFIG   = 4'h0;
	localparam logic [3:0] OFF_BASE     = 4'h2;
	localparam logic [3:0] OFF_COUNTERS = 4'h6;
	localparam logic [3:0] OFF_MEMINFO  = 4'h8;
	localparam logic [3:0] OFF_MEMSETUP = 4'hA;
	// an own-register holding the receive-abort flag in bit 0
	localparam logic [3:0] OFF_RXSTAT   = 4'h4;
	// configuration field positions
	localparam int CFG_PORT_BIT     = 0;
	localparam int CFG_SQUELCH_BIT  = 1;
	localparam int CFG_FULLSTEP_BIT = 2;
	localparam int CFG_NOWAIT_BIT   = 4;
	localparam int CFG_IRQSEL_LSB   = 9;
	localparam int CFG_LINKDIS_BIT  = 14;
	localparam int CFG_WIDE_BIT     = 15;
	// writable mask and fixed reserved pattern of the configuration register
	localparam logic [15:0] CFG_WR_MASK  = 16'hC617;
	localparam logic [15:0] CFG_FIXED    = 16'h3000;
	localparam logic [15:0] CFG_RESET    = 16'h0000;
	localparam logic [15:0] BASE_RESET   = 16'h1867;
	// memory figures
	localparam logic [7:0]  MEM_SIZE     = 8'h18;
	localparam logic [2:0]  MEM_MULT_ONE = 3'b001;
	localparam logic [7:0]  RESERVE_RESET = 8'h00;
	localparam logic [10:0] MAX_FRAME_BYTES = 11'd1532;
	localparam logic [3:0]  CNT_MAX      = 4'hF;
	// wait-state timing: 20 MHz periods turned into core clocks
	localparam int CORE_MHZ       = 125;
	localparam int WAIT_REF_MHZ   = 20;
	localparam int WAIT_PERIODS   = 2;
	localparam int WAIT_CYCLES    = (WAIT_PERIODS * CORE_MHZ + WAIT_REF_MHZ - 1) / WAIT_REF_MHZ;
	localparam logic [4:0] WAIT_CNT = 5'(WAIT_CYCLES);

	// host bus request
	typedef struct packed {
		logic        cycle;
		logic        write;
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        dataPort;
		logic        dataReady;
	} msr_bus_req_t;

	// per-packet transmit completion status
	typedef struct packed {
		logic       done;
		logic [4:0] collisions;
		logic       deferred;
		logic       excDeferral;
	} msr_tx_status_t;
endpackage

/* File: verilog/msr_regs.sv */
// module: register bank for transmit statistics, buffer memory and device configuration
`timescale 1ns/1ps
`default_nettype none
module msr_regs (
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	// host register access
	input  wire msr_pkg::msr_bus_req_t   busReq,
	output logic [15:0]                  rdData,
	output logic                         ioChRdy,
	// width strap, low forces wide bus
	input  wire logic                    wideBusStrap_n,
	input  wire logic                    isaMode,
	// receive side
	input  wire logic                    rxFrameEnd,
	input  wire logic [10:0]             rxFrameLen,
	input  wire logic                    rxFrameIsOwnTx,
	input  wire logic                    fullDuplexSelect,
	output logic                         rxAccept,
	output logic                         rxDiscard,
	// transmit completion status
	input  wire msr_pkg::msr_tx_status_t txStatus,
	// memory manager
	input  wire logic                    memoryManagerResetCmd,
	input  wire logic                    memAlloc,
	input  wire logic                    memRelease,
	input  wire logic [7:0]              memPages,
	input  wire logic                    rxAllocReq,
	output logic                         rxAllocGrant,
	// link
	input  wire logic                    linkPulseOk,
	output logic                         linkGood,
	output logic                         linkLed,
	output logic                         linkPulseEnable,
	output logic                         cableTxEnable,
	// port options
	output logic                         portSelect,
	output logic                         fullStepSelect,
	output logic                         lowSquelchSelect,
	output logic                         wideBusSelect,
	// interrupt pins, output and enable each
	input  wire logic                    statIrqOther,
	output logic [3:0]                   irqOut,
	output logic [3:0]                   irqOutEn
);
	//--------------------------------------------------------------------------
	// decode
	//--------------------------------------------------------------------------
	// equality match of a request address against an offset
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction

	logic        cfgWr;       // write to configuration
	logic        baseWr;      // write to base address
	logic        setupWr;     // write to reservation byte
	logic        statWr;      // write to abort status
	logic        cntRd;       // read of counter register
	logic        cycStart_q;  // previous cycle strobe for edge
	logic        cycStart;    // first edge of a host cycle
	// a cycle may be stretched, so act once per cycle, not once per edge
	assign cycStart = busReq.cycle & ~cycStart_q;
	assign cfgWr   = busReq.cycle & busReq.write & hit(busReq.addr, msr_pkg::OFF_CONFIG);
	assign baseWr  = busReq.cycle & busReq.write & hit(busReq.addr, msr_pkg::OFF_BASE);
	assign setupWr = busReq.cycle & busReq.write & hit(busReq.addr, msr_pkg::OFF_MEMSETUP);
	assign statWr  = busReq.cycle & busReq.write & hit(busReq.addr, msr_pkg::OFF_RXSTAT);
	// clear once per read, so events during wait states are still counted
	assign cntRd   = cycStart & ~busReq.write & hit(busReq.addr, msr_pkg::OFF_COUNTERS);

	//--------------------------------------------------------------------------
	// configuration and base registers
	//--------------------------------------------------------------------------
	logic [15:0] cfg_q;       // stored writable bits
	logic [15:0] cfg_d;
	logic [15:0] base_q;      // base address, stored only
	logic [15:0] cfgView;     // value as read back
	assign cfg_d = cfgWr ? (busReq.wdata & msr_pkg::CFG_WR_MASK) : cfg_q;
	// strap low overrides the stored width bit
	assign cfgView = cfg_q | msr_pkg::CFG_FIXED
		| {~wideBusStrap_n, 15'h0000}; // see R20

	// all fields reset to defaults: port, squelch, full-step low
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_q  <= msr_pkg::CFG_RESET; // see R18 see R19 see R20
			base_q <= msr_pkg::BASE_RESET;
		end else begin
			cfg_q <= cfg_d;
			if (baseWr) begin
				base_q <= busReq.wdata;
			end
		end
	end

	//--------------------------------------------------------------------------
	// receive abort and own-frame filter
	//--------------------------------------------------------------------------
	logic rxAbort_q;          // sticky oversize flag
	logic tooLong;            // current frame exceeds limit
	logic ownReject;          // half duplex echo of own frame
	assign tooLong   = rxFrameEnd & (rxFrameLen > msr_pkg::MAX_FRAME_BYTES); // see R1
	assign ownReject = rxFrameIsOwnTx & ~fullDuplexSelect;                    // see R3

	// set wins over a host clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rxAbort_q <= 1'b0;
			rxAccept  <= 1'b0;
			rxDiscard <= 1'b0;
		end else begin
			if (tooLong) begin
				rxAbort_q <= 1'b1; // see R1
			end else if (statWr && !busReq.wdata[0]) begin
				rxAbort_q <= 1'b0; // see R2
			end
			rxAccept  <= rxFrameEnd & ~tooLong & ~ownReject;
			rxDiscard <= rxFrameEnd & (tooLong | ownReject); // see R1 see R3
		end
	end

	//--------------------------------------------------------------------------
	// statistics counters
	//--------------------------------------------------------------------------
	logic [3:0] cnt_q [4];    // single, multiple, deferred, excessive
	logic [3:0] evt;          // one event bit per counter, once per packet
	logic       statIrq_q;    // any counter at the top, or the other status interrupt
	assign evt[0] = txStatus.done & (txStatus.collisions == 5'd1);             // see R9
	assign evt[1] = txStatus.done & (txStatus.collisions >= 5'd2)
		& (txStatus.collisions <= 5'd16);                                     // see R9
	assign evt[2] = txStatus.done & txStatus.deferred;                         // see R10
	assign evt[3] = txStatus.done & txStatus.excDeferral;                      // see R25

	// status arrives once per packet, so a counter moves once at most
	generate
		for (genvar i = 0; i < 4; i++) begin : g_cnt
			always_ff @(posedge core_clk) begin
				if (rst || cntRd) begin
					cnt_q[i] <= 4'h0; // see R6
				end else if (evt[i] && cnt_q[i] != msr_pkg::CNT_MAX) begin
					cnt_q[i] <= cnt_q[i] + 4'h1; // see R4 see R7 see R8
				end
			end
		end
	endgenerate

	// counter view packed low to high
	logic [15:0] cntView;
	assign cntView = {cnt_q[3], cnt_q[2], cnt_q[1], cnt_q[0]}; // see R24

	//--------------------------------------------------------------------------
	// buffer memory accounting
	//--------------------------------------------------------------------------
	logic [7:0] free_q;       // free pages of 256 bytes
	logic [7:0] reserve_q;    // pages held back for transmit
	logic       denyRx;
	// an event is lost against a read clear in the same cycle: accepted loss
	assign denyRx = (reserve_q != 8'h00) & (free_q <= reserve_q); // see R14

	always_ff @(posedge core_clk) begin
		if (rst || memoryManagerResetCmd) begin
			free_q <= msr_pkg::MEM_SIZE; // see R12
		end else if (memAlloc && !memRelease) begin
			free_q <= (free_q > memPages) ? free_q - memPages : 8'h00;
		end else if (memRelease && !memAlloc) begin
			free_q <= free_q + memPages;
		end
	end

	// manager reset leaves the reservation alone
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reserve_q    <= msr_pkg::RESERVE_RESET; // see R15
			rxAllocGrant <= 1'b0;
		end else begin
			if (setupWr) begin
				reserve_q <= busReq.wdata[7:0];
			end
			rxAllocGrant <= rxAllocReq & ~denyRx; // see R14
		end
	end

	//--------------------------------------------------------------------------
	// read mux
	//--------------------------------------------------------------------------
	logic [15:0] rdMux;
	always_comb begin
		rdMux = 16'h0000;
		case (busReq.addr)
			msr_pkg::OFF_CONFIG:   rdMux = cfgView;
			msr_pkg::OFF_BASE:     rdMux = base_q;
			msr_pkg::OFF_RXSTAT:   rdMux = {15'h0000, rxAbort_q};
			msr_pkg::OFF_COUNTERS: rdMux = cntView;
			msr_pkg::OFF_MEMINFO:  rdMux = {msr_pkg::MEM_SIZE, free_q};        // see R11 see R13
			msr_pkg::OFF_MEMSETUP: rdMux = {4'h0, msr_pkg::MEM_MULT_ONE, 1'b0, reserve_q}; // see R16
			default:               rdMux = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdData <= 16'h0000;
		end else if (cycStart && !busReq.write) begin
			// captured once, stands until ready so the host takes it then
			rdData <= rdMux;
		end
	end

	//--------------------------------------------------------------------------
	// wait-state generator
	//--------------------------------------------------------------------------
	logic [4:0] wait_q;       // remaining not-ready cycles
	logic       slowBus;      // no-wait clear: stretch every cycle
	logic       dataHold;     // data access before the data path is ready
	assign slowBus  = ~cfg_q[msr_pkg::CFG_NOWAIT_BIT];                     // see R17
	assign dataHold = busReq.cycle & busReq.dataPort & ~busReq.dataReady; // see R17

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wait_q     <= 5'd0;
			cycStart_q <= 1'b0;
			ioChRdy    <= 1'b1;
		end else begin
			cycStart_q <= busReq.cycle;
			if (cycStart && slowBus) begin
				wait_q  <= msr_pkg::WAIT_CNT; // see R17
				ioChRdy <= 1'b0;
			end else if (wait_q > 5'd1) begin
				wait_q <= wait_q - 5'd1;
			end else if (dataHold) begin
				// data path not ready: hold off until it is
				wait_q  <= 5'd0;
				ioChRdy <= 1'b0;
			end else begin
				wait_q  <= 5'd0;
				ioChRdy <= 1'b1;
			end
		end
	end

	//--------------------------------------------------------------------------
	// link, port and interrupt outputs
	//--------------------------------------------------------------------------
	logic linkDis;
	logic irqAny;
	logic [1:0] irqSel;
	assign linkDis = cfg_q[msr_pkg::CFG_LINKDIS_BIT];
	assign irqAny  = statIrqOther
		| (cnt_q[0] == msr_pkg::CNT_MAX) | (cnt_q[1] == msr_pkg::CNT_MAX)
		| (cnt_q[2] == msr_pkg::CNT_MAX) | (cnt_q[3] == msr_pkg::CNT_MAX); // see R5
	assign irqSel  = cfg_q[msr_pkg::CFG_IRQSEL_LSB +: 2];

	// registered so every output comes from a flip-flop
	always_ff @(posedge core_clk) begin
		if (rst) begin
			linkGood         <= 1'b1;
			linkLed          <= 1'b1;
			linkPulseEnable  <= 1'b0;
			cableTxEnable    <= 1'b0;
			portSelect       <= 1'b0;
			fullStepSelect   <= 1'b0;
			lowSquelchSelect <= 1'b0;
			wideBusSelect    <= 1'b0;
			irqOut           <= 4'h0;
			irqOutEn         <= 4'h0;
			statIrq_q        <= 1'b0;
		end else begin
			linkGood         <= linkDis | linkPulseOk;   // see R21 see R22
			linkLed          <= linkDis | linkPulseOk;   // see R21
			linkPulseEnable  <= ~linkDis;                // see R21
			cableTxEnable    <= linkDis | linkPulseOk;   // see R22
			portSelect       <= cfg_q[msr_pkg::CFG_PORT_BIT];     // see R18
			fullStepSelect   <= cfg_q[msr_pkg::CFG_FULLSTEP_BIT]
				& cfg_q[msr_pkg::CFG_PORT_BIT];                   // see R18
			lowSquelchSelect <= cfg_q[msr_pkg::CFG_SQUELCH_BIT];  // see R19
			wideBusSelect    <= cfgView[msr_pkg::CFG_WIDE_BIT];   // see R20
			statIrq_q        <= irqAny;
			irqOut           <= {4{irqAny}} & (4'h1 << irqSel);   // see R23
			irqOutEn         <= isaMode ? (4'h1 << irqSel) : 4'h0; // see R23
		end
	end

	//--------------------------------------------------------------------------
	// assertions
	//--------------------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	abort_sets_a: assert property (tooLong |=> rxAbort_q) // see R1
		else $error("abort flag not set on oversize frame");
	abort_sticks_a: assert property (rxAbort_q && !(statWr && !busReq.wdata[0]) |=> rxAbort_q) // see R2
		else $error("abort flag dropped without clear");
	own_reject_a: assert property (rxFrameEnd && rxFrameIsOwnTx && !fullDuplexSelect |=> !rxAccept) // see R3
		else $error("own frame accepted in half duplex");
	cnt_clear_a: assert property (cntRd |=> cntView == 16'h0000) // see R6
		else $error("counters not cleared by read");
	cnt_saturate_a: assert property (cnt_q[0] == 4'hF && !cntRd |=> cnt_q[0] == 4'hF) // see R7
		else $error("counter wrapped past top");
	single_step_a: assert property (evt[0] && !cntRd && cnt_q[0] != 4'hF
		|=> cnt_q[0] == $past(cnt_q[0]) + 4'h1) // see R9
		else $error("single collision count not advanced");
	mem_reset_a: assert property (memoryManagerResetCmd |=> free_q == 8'h18 && $stable(reserve_q)) // see R12
		else $error("manager reset handled wrongly");
	deny_rx_a: assert property (rxAllocReq && denyRx |=> !rxAllocGrant) // see R14
		else $error("receive allocation granted inside reservation");
	irq_route_a: assert property (isaMode |=> $onehot(irqOutEn)) // see R23
		else $error("interrupt enables not one-hot");
	wait_len_a: assert property ($fell(ioChRdy) && wait_q != 5'd0
		|-> !ioChRdy [*8] ##1 !ioChRdy [*5] ##[1:6] ioChRdy) // see R17
		else $error("wait stretch wrong length");

	abort_c:   cover property (tooLong);
	sat_c:     cover property (cnt_q[1] == 4'hF);
	deny_c:    cover property (rxAllocReq && denyRx);
	wait_c:    cover property ($rose(ioChRdy));
endmodule
`default_nettype wire

/* File: sim/msr_host_model.sv */
// host processor model issuing register cycles on the controller's host bus
`timescale 1ns/1ps
`default_nettype none
module msr_host_model (
	// clock
	input  wire logic             core_clk,
	// bus towards the register bank
	output msr_pkg::msr_bus_req_t busReq,
	input  wire logic [15:0]      rdData,
	input  wire logic             ioChRdy
);
	// idle bus at time zero
	initial busReq = '0;

	//------------------------------------------------------------
	// one access: held until ready, read data taken once ready
	//------------------------------------------------------------
	task automatic access(input logic wr, input logic [3:0] a, input logic [15:0] wd,
		input logic dp, output logic [15:0] rd, output int waits);
		waits = 0;
		@(negedge core_clk);
		busReq <= '{cycle:1'b1, write:wr, addr:a, wdata:wd, dataPort:dp, dataReady:1'b0};
		@(negedge core_clk);
		while (ioChRdy !== 1'b1 && waits < 40) begin
			waits++;
			// the data path turns ready late, so the slow case is exercised
			if (waits == 3)
				busReq.dataReady <= 1'b1;
			@(negedge core_clk);
		end
		// answer taken where ready is seen
		rd = rdData;
		// released write, address and data lines show the inverse, never the stale value; data port and ready go low
		busReq <= '{cycle:1'b0, write:~wr, addr:~a, wdata:~wd, dataPort:1'b0, dataReady:1'b0};
	endtask
endmodule
`default_nettype wire

/* File: sim/mac_stats_memory_config_regs_test.sv */
// self-checking bench for the stats, memory and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module mac_stats_memory_config_regs_test;
	//------------------------------------------------------------
	// signals
	//------------------------------------------------------------
	logic                   core_clk = 1'b0;
	logic                   rst = 1'b1;
	msr_pkg::msr_bus_req_t  busReq;
	msr_pkg::msr_tx_status_t txStatus = '0;
	logic [15:0]            rdData;
	logic                   ioChRdy, rxAccept, rxDiscard, rxAllocGrant, linkGood, linkLed;
	logic                   linkPulseEnable, cableTxEnable, portSelect, fullStepSelect;
	logic                   lowSquelchSelect, wideBusSelect;
	logic [3:0]             irqOut, irqOutEn;
	logic                   wideBusStrap_n = 1'b1, isaMode = 1'b1, rxFrameEnd = 1'b0;
	logic [10:0]            rxFrameLen = '0;
	logic                   rxFrameIsOwnTx = 1'b0, fullDuplexSelect = 1'b0, mmuRst = 1'b0;
	logic                   memAlloc = 1'b0, memRelease = 1'b0, rxAllocReq = 1'b0;
	logic [7:0]             memPages = '0;
	logic                   linkPulseOk = 1'b1, statIrqOther = 1'b0;
	int                     nFail = 0, totalChecks = 0, cycles = 0;

	// 125 MHz clock
	always #4 core_clk = ~core_clk;

	msr_host_model host (.core_clk(core_clk), .busReq(busReq), .rdData(rdData), .ioChRdy(ioChRdy));

	msr_regs dut (.core_clk(core_clk), .rst(rst), .busReq(busReq), .rdData(rdData), .ioChRdy(ioChRdy),
		.wideBusStrap_n(wideBusStrap_n), .isaMode(isaMode), .rxFrameEnd(rxFrameEnd),
		.rxFrameLen(rxFrameLen), .rxFrameIsOwnTx(rxFrameIsOwnTx), .fullDuplexSelect(fullDuplexSelect),
		.rxAccept(rxAccept), .rxDiscard(rxDiscard), .txStatus(txStatus),
		.memoryManagerResetCmd(mmuRst), .memAlloc(memAlloc), .memRelease(memRelease),
		.memPages(memPages), .rxAllocReq(rxAllocReq), .rxAllocGrant(rxAllocGrant),
		.linkPulseOk(linkPulseOk), .linkGood(linkGood), .linkLed(linkLed),
		.linkPulseEnable(linkPulseEnable), .cableTxEnable(cableTxEnable), .portSelect(portSelect),
		.fullStepSelect(fullStepSelect), .lowSquelchSelect(lowSquelchSelect),
		.wideBusSelect(wideBusSelect), .statIrqOther(statIrqOther), .irqOut(irqOut), .irqOutEn(irqOutEn));

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	task automatic completeRun();
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// compare and count; unknowns never match
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		totalChecks++;
		if (got !== exp) begin
			nFail++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		int w;
		host.access(1'b0, a, 16'h0000, 1'b0, v, w);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		logic [15:0] v;
		int w;
		host.access(1'b1, a, d, 1'b0, v, w);
		// registered outputs follow the stored value one edge later
		@(negedge core_clk);
	endtask

	// one transmit completion, done high for one cycle
	task automatic tx(input logic [4:0] c, input logic d, input logic e);
		@(negedge core_clk);
		txStatus <= '{done:1'b1, collisions:c, deferred:d, excDeferral:e};
		@(negedge core_clk);
		txStatus <= '{done:1'b0, collisions:~c, deferred:~d, excDeferral:~e};
	endtask

	// one frame end; verdict pulses seen one cycle later
	task automatic rx(input logic [10:0] n, input logic own, input logic fd, output logic [1:0] r);
		@(negedge core_clk);
		{rxFrameEnd, rxFrameLen, rxFrameIsOwnTx, fullDuplexSelect} <= {1'b1, n, own, fd};
		@(negedge core_clk);
		rxFrameEnd <= 1'b0;
		r = {rxAccept, rxDiscard};
	endtask

	// memory manager pulses: reset, alloc, release, receive request
	task automatic mem(input logic [3:0] k, input logic [7:0] p, output logic g);
		@(negedge core_clk);
		{mmuRst, memAlloc, memRelease, rxAllocReq, memPages} <= {k, p};
		@(negedge core_clk);
		{mmuRst, memAlloc, memRelease, rxAllocReq} <= 4'h0;
		g = rxAllocGrant;
	endtask

	//------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------
	task automatic tReset();
		logic [15:0] v;
		int w;
		host.access(1'b0, msr_pkg::OFF_CONFIG, 16'h0000, 1'b0, v, w);
		check(v, msr_pkg::CFG_FIXED, "config reset");
		check(16'(w >= 12 && w <= 19), 16'h0001, "wait states");
		rd(msr_pkg::OFF_MEMINFO, v);
		check(v, 16'h1818, "mem info");
		rd(msr_pkg::OFF_MEMSETUP, v);
		check(v & 16'h0EFF, 16'h0200, "mem setup");
		wr(4'hC, 16'hFFFF);
		rd(4'hC, v);
		check(v, 16'h0000, "unmapped");
		$display("reset test done");
	endtask

	task automatic tConfig();
		logic [15:0] v;
		int w;
		wr(msr_pkg::OFF_CONFIG, 16'h0017);
		host.access(1'b0, msr_pkg::OFF_CONFIG, 16'h0000, 1'b0, v, w);
		check(v, 16'h3017, "config readback");
		check(16'(w), 16'h0000, "no wait");
		check({portSelect, fullStepSelect, lowSquelchSelect}, 3'b111, "aui full step low squelch");
		wr(msr_pkg::OFF_CONFIG, 16'h0014);
		check({portSelect, fullStepSelect, lowSquelchSelect}, 3'b000, "twisted pair");
		host.access(1'b0, msr_pkg::OFF_BASE, 16'h0000, 1'b1, v, w);
		check(16'(w >= 3 && w <= 6), 16'h0001, "data port stretch");
		wr(msr_pkg::OFF_CONFIG, 16'h8010);
		check(wideBusSelect, 1'b1, "wide written");
		wr(msr_pkg::OFF_CONFIG, 16'h0010);
		check(wideBusSelect, 1'b0, "wide cleared");
		wideBusStrap_n <= 1'b0;
		rd(msr_pkg::OFF_CONFIG, v);
		check({v[15], wideBusSelect}, 2'b11, "wide forced");
		wideBusStrap_n <= 1'b1;
		$display("config test done");
	endtask

	task automatic tCounters();
		logic [15:0] v;
		tx(5'd1, 1'b0, 1'b0);
		tx(5'd1, 1'b1, 1'b0);
		tx(5'd2, 1'b0, 1'b0);
		tx(5'd16, 1'b1, 1'b1);
		tx(5'd0, 1'b0, 1'b0);
		rd(msr_pkg::OFF_COUNTERS, v);
		check(v, 16'h1222, "counter fields");
		rd(msr_pkg::OFF_COUNTERS, v);
		check(v, 16'h0000, "clear on read");
		repeat (17) tx(5'd1, 1'b0, 1'b0);
		rd(msr_pkg::OFF_COUNTERS, v);
		check(v, 16'h000F, "saturate");
		$display("counter test done");
	endtask

	task automatic tIrq();
		logic [15:0] v;
		for (int s = 0; s < 4; s++) begin
			wr(msr_pkg::OFF_CONFIG, 16'h0010 | 16'(s << 9));
			statIrqOther <= 1'b1;
			repeat (3) @(negedge core_clk);
			check({irqOutEn, irqOut[s]}, {4'(1 << s), 1'b1}, "irq routing");
			statIrqOther <= 1'b0;
		end
		wr(msr_pkg::OFF_CONFIG, 16'h0410);
		rd(msr_pkg::OFF_COUNTERS, v);
		repeat (14) tx(5'd0, 1'b1, 1'b0);
		repeat (2) @(negedge core_clk);
		check(irqOut[2], 1'b0, "irq below 15");
		tx(5'd0, 1'b1, 1'b0);
		repeat (2) @(negedge core_clk);
		check(irqOut[2], 1'b1, "irq at 15");
		rd(msr_pkg::OFF_COUNTERS, v);
		$display("irq test done");
	endtask

	task automatic tRx();
		logic [1:0] r;
		logic [15:0] v;
		rx(11'd1533, 1'b0, 1'b0, r);
		check(r, 2'b01, "oversize dropped");
		rx(11'd1532, 1'b0, 1'b0, r);
		check(r, 2'b10, "max size kept");
		rd(msr_pkg::OFF_RXSTAT, v);
		check(v[0], 1'b1, "abort sticks");
		wr(msr_pkg::OFF_RXSTAT, 16'h0000);
		rd(msr_pkg::OFF_RXSTAT, v);
		check(v[0], 1'b0, "abort cleared");
		rx(11'd100, 1'b1, 1'b0, r);
		check(r[1], 1'b0, "own frame half duplex");
		rx(11'd100, 1'b1, 1'b1, r);
		check(r, 2'b10, "own frame full duplex");
		$display("receive test done");
	endtask

	task automatic tMem();
		logic g;
		logic [15:0] v;
		wr(msr_pkg::OFF_MEMSETUP, 16'h0004);
		mem(4'h4, 8'h14, g);
		rd(msr_pkg::OFF_MEMINFO, v);
		check(v, 16'h1804, "free after alloc");
		mem(4'h1, 8'h00, g);
		check(g, 1'b0, "denied at reserve");
		mem(4'h2, 8'h01, g);
		mem(4'h1, 8'h00, g);
		check(g, 1'b1, "granted above reserve");
		mem(4'h8, 8'h00, g);
		rd(msr_pkg::OFF_MEMINFO, v);
		check(v, 16'h1818, "free reload");
		rd(msr_pkg::OFF_MEMSETUP, v);
		check(v[7:0], 8'h04, "reserve kept");
		wr(msr_pkg::OFF_MEMSETUP, 16'h0000);
		mem(4'h4, 8'h18, g);
		mem(4'h1, 8'h00, g);
		check(g, 1'b1, "zero reserve dynamic");
		mem(4'h8, 8'h00, g);
		$display("memory test done");
	endtask

	task automatic tLink();
		wr(msr_pkg::OFF_CONFIG, 16'h0010);
		linkPulseOk <= 1'b0;
		repeat (4) @(negedge core_clk);
		check({linkGood, cableTxEnable, linkPulseEnable}, 3'b001, "link failed");
		linkPulseOk <= 1'b1;
		repeat (4) @(negedge core_clk);
		check({linkGood, cableTxEnable, linkPulseEnable}, 3'b111, "link up");
		wr(msr_pkg::OFF_CONFIG, 16'h4010);
		linkPulseOk <= 1'b0;
		repeat (4) @(negedge core_clk);
		check({linkGood, linkLed, cableTxEnable, linkPulseEnable}, 4'b1110, "link test off");
		$display("link test done");
	endtask

	//------------------------------------------------------------
	// hang guard and main sequence
	//------------------------------------------------------------
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			nFail++;
			$display("unexpected at %0t: run did not finish", $time);
			completeRun();
		end
	end

	initial begin
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		rst <= 1'b0;
		tReset();
		tConfig();
		tCounters();
		tIrq();
		tRx();
		tMem();
		tLink();
		completeRun();
	end
endmodule
`default_nettype wire
